// ---- src/wcts_pkg.sv ----
// Purpose: shared constants and types of the weekly cam time switch
// Assumes: time base supplied by an external calendar on pclk
// Notes: register map, slot field layout, reset values
package wcts_pkg;
   localparam int unsigned CAM_NUM = 3;
   localparam int unsigned DAY_NUM = 7;
   localparam logic [2:0] DAY_LAST = 3'h6;
   localparam logic [3:0] CAM_LAST = 4'h2;
   // apb byte offsets, one block of words per cam
   localparam logic [7:0] OFS_STATUS = 8'h30;
   localparam int unsigned ADDR_W = 8;
   // time slot: minute, hour, set flag (clear = unset marker)
   localparam int unsigned TM_W = 12;
   localparam int unsigned TM_MIN_LSB = 0;
   localparam int unsigned TM_MIN_W = 6;
   localparam int unsigned TM_HOUR_LSB = 6;
   localparam int unsigned TM_HOUR_W = 5;
   localparam int unsigned TM_SET_BIT = 11;
   localparam logic [TM_W-1:0] TIME_RST = 12'h000;
   // day mask bit 0 is monday, bit 6 sunday; one means selected
   localparam logic [DAY_NUM-1:0] DAYS_RST = 7'h00;
   // status word fields
   localparam int unsigned ST_OUT_BIT = 0;
   localparam int unsigned ST_MIN_LSB = 8;
   localparam int unsigned ST_HOUR_LSB = 16;
   localparam int unsigned ST_DAY_LSB = 24;
   typedef enum logic [1:0] {
      WCTS_ACT_HOLD = 2'b00,
      WCTS_ACT_SET = 2'b01,
      WCTS_ACT_CLR = 2'b10
   } wcts_act_t;
   typedef enum logic [1:0] {
      WCTS_KIND_DAYS = 2'b00,
      WCTS_KIND_ON = 2'b01,
      WCTS_KIND_OFF = 2'b10,
      WCTS_KIND_STATUS = 2'b11
   } wcts_kind_t;
   typedef struct packed {
      logic hit;
      logic [1:0] cam;
      wcts_kind_t kind;
   } wcts_sel_t;
endpackage

// ---- src/wcts_cam_if.sv ----
// Purpose: carrier between switch core and one cam comparator
// Assumes: all signals on pclk
// Notes: time base is fanned out to every cam
`timescale 1ns/1ps
interface wcts_cam_if;
   import wcts_pkg::*;
   logic [DAY_NUM-1:0] days;
   logic [TM_W-1:0] on_time;
   logic [TM_W-1:0] off_time;
   logic [2:0] cur_day;
   logic [TM_HOUR_W-1:0] cur_hour;
   logic [TM_MIN_W-1:0] cur_min;
   wcts_act_t act;
   modport ctl (output days, output on_time, output off_time, output cur_day, output cur_hour,
      output cur_min, input act);
   modport cam (input days, input on_time, input off_time, input cur_day, input cur_hour,
      input cur_min, output act);
endinterface

// ---- src/wcts_cam.sv ----
// Purpose: one cam, compares its slots with the time base
// Assumes: time base stable for the evaluation cycle
// Notes: purely combinational
`timescale 1ns/1ps
module wcts_cam
   import wcts_pkg::*;
(
   wcts_cam_if.cam cb
);
   function automatic logic slot_hit(input logic [TM_W-1:0] slot, input logic [TM_HOUR_W-1:0] hr,
      input logic [TM_MIN_W-1:0] mn);
      slot_hit = slot[TM_SET_BIT] && (slot[TM_HOUR_LSB +: TM_HOUR_W] == hr) &&
         (slot[TM_MIN_LSB +: TM_MIN_W] == mn);
   endfunction

   logic day_sel;

   always_comb begin
      day_sel = 1'b0;
      if (cb.cur_day <= DAY_LAST) begin
         day_sel = cb.days[cb.cur_day];
      end
      cb.act = WCTS_ACT_HOLD;
      if (day_sel && slot_hit(cb.on_time, cb.cur_hour, cb.cur_min)) begin
         cb.act = WCTS_ACT_SET;
      end
      // off wins when one cam holds equal on and off times
      if (day_sel && slot_hit(cb.off_time, cb.cur_hour, cb.cur_min)) begin
         cb.act = WCTS_ACT_CLR;
      end
   end
endmodule

// ---- src/wcts_top.sv ----
// Purpose: weekly time switch, three cams on one output, apb registers
// Assumes: calendar inputs come from logic on pclk, no synchroniser
// Notes: zero wait state slave, unmapped access answers pslverr
//
// Function
// - three independent cams drive one output
// - selected day and on time sets output
// - selected day and off time clears output
// - conflicts: cam three beats two beats one
// - output follows combined events of all cams
// - seven day mask, monday to sunday
// - letter means selected, dash means not
// - times in hours and minutes, whole day
// - unset slot never switches
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module wcts_top
   import wcts_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] cur_day,
   input wire logic [TM_HOUR_W-1:0] cur_hour,
   input wire logic [TM_MIN_W-1:0] cur_min,
   output logic switch_out
);
   localparam int unsigned TB_W = 3 + TM_HOUR_W + TM_MIN_W;

   function automatic wcts_sel_t reg_sel(input logic [ADDR_W-1:0] a);
      reg_sel = '0;
      if (a == OFS_STATUS) begin
         reg_sel.hit = 1'b1;
         reg_sel.kind = WCTS_KIND_STATUS;
      end else if ((a[1:0] == 2'h0) && (a[7:4] <= CAM_LAST) && (a[3:2] != 2'h3)) begin
         reg_sel.hit = 1'b1;
         reg_sel.cam = a[5:4];
         reg_sel.kind = wcts_kind_t'(a[3:2]);
      end
   endfunction

   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
      input logic [3:0] strb);
      lane_merge = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            lane_merge[8*b +: 8] = wd[8*b +: 8];
         end
      end
   endfunction

   logic [DAY_NUM-1:0] days_ff [CAM_NUM];
   logic [TM_W-1:0] on_ff [CAM_NUM];
   logic [TM_W-1:0] off_ff [CAM_NUM];
   wcts_act_t acts [CAM_NUM];
   logic [TB_W-1:0] tb_prev_ff;
   logic tb_valid_ff;
   logic eval;
   logic sw_out_ff;
   logic nxt_sw_out;
   logic [31:0] prdata_ff;
   logic [31:0] rd_val;
   wcts_sel_t sel;
   logic wr_go;
   logic [31:0] merged;

   assign sel = reg_sel(paddr);
   assign wr_go = psel && penable && pwrite && sel.hit;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !sel.hit;
   assign prdata = prdata_ff;
   assign switch_out = sw_out_ff;

   // three cams share the time base and one output
   genvar g;
   generate
      for (g = 0; g < CAM_NUM; g++) begin : gen_cam
         wcts_cam_if cb ();
         assign cb.days = days_ff[g];
         assign cb.on_time = on_ff[g];
         assign cb.off_time = off_ff[g];
         assign cb.cur_day = cur_day;
         assign cb.cur_hour = cur_hour;
         assign cb.cur_min = cur_min;
         assign acts[g] = cb.act;
         wcts_cam u_cam (
            .cb(cb)
         );
      end
   endgenerate

   // register writes; status is read only
   always_comb begin
      merged = '0;
      case (sel.kind)
         WCTS_KIND_DAYS: merged = lane_merge({25'h0, days_ff[sel.cam]}, pwdata, pstrb);
         WCTS_KIND_ON: merged = lane_merge({20'h00000, on_ff[sel.cam]}, pwdata, pstrb);
         WCTS_KIND_OFF: merged = lane_merge({20'h00000, off_ff[sel.cam]}, pwdata, pstrb);
         default: merged = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < CAM_NUM; i++) begin
            days_ff[i] <= DAYS_RST;
            on_ff[i] <= TIME_RST;
            off_ff[i] <= TIME_RST;
         end
      end else if (wr_go) begin
         case (sel.kind)
            WCTS_KIND_DAYS: days_ff[sel.cam] <= merged[DAY_NUM-1:0];
            WCTS_KIND_ON: on_ff[sel.cam] <= merged[TM_W-1:0];
            WCTS_KIND_OFF: off_ff[sel.cam] <= merged[TM_W-1:0];
            default: ;
         endcase
      end
   end

   // read data captured in the setup cycle so the access cycle needs no wait
   always_comb begin
      rd_val = '0;
      case (sel.kind)
         WCTS_KIND_DAYS: rd_val[DAY_NUM-1:0] = days_ff[sel.cam];
         WCTS_KIND_ON: rd_val[TM_W-1:0] = on_ff[sel.cam];
         WCTS_KIND_OFF: rd_val[TM_W-1:0] = off_ff[sel.cam];
         WCTS_KIND_STATUS: begin
            rd_val[ST_OUT_BIT] = sw_out_ff;
            rd_val[ST_MIN_LSB +: TM_MIN_W] = cur_min;
            rd_val[ST_HOUR_LSB +: TM_HOUR_W] = cur_hour;
            rd_val[ST_DAY_LSB +: 3] = cur_day;
         end
         default: rd_val = '0;
      endcase
      if (!sel.hit) begin
         rd_val = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata_ff <= rd_val;
      end
   end

   // day, hour or minute change detector; first sample after reset only arms it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tb_prev_ff <= '0;
         tb_valid_ff <= 1'b0;
      end else begin
         tb_prev_ff <= {cur_day, cur_hour, cur_min};
         tb_valid_ff <= 1'b1;
      end
   end

   assign eval = tb_valid_ff && (tb_prev_ff != {cur_day, cur_hour, cur_min});

   // later cams overwrite earlier ones, so cam three has last word
   always_comb begin
      nxt_sw_out = sw_out_ff;
      if (eval) begin
         for (int i = 0; i < CAM_NUM; i++) begin
            case (acts[i])
               WCTS_ACT_SET: nxt_sw_out = 1'b1;
               WCTS_ACT_CLR: nxt_sw_out = 1'b0;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_out_ff <= 1'b0;
      end else begin
         sw_out_ff <= nxt_sw_out;
      end
   end

   default clocking cb_clk @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_rise_needs_set: assert property ($rose(sw_out_ff) |-> $past(eval) &&
      ($past(acts[0]) == WCTS_ACT_SET || $past(acts[1]) == WCTS_ACT_SET || $past(acts[2]) == WCTS_ACT_SET))
      else $error("output rose without an on event");

   a_fall_needs_clr: assert property ($fell(sw_out_ff) |-> $past(eval) &&
      ($past(acts[0]) == WCTS_ACT_CLR || $past(acts[1]) == WCTS_ACT_CLR || $past(acts[2]) == WCTS_ACT_CLR))
      else $error("output fell without an off event");

   a_third_cam_wins: assert property (eval && acts[2] != WCTS_ACT_HOLD |=>
      sw_out_ff == ($past(acts[2]) == WCTS_ACT_SET))
      else $error("third cam did not take priority");

   a_second_over_first: assert property (eval && acts[2] == WCTS_ACT_HOLD &&
      acts[1] != WCTS_ACT_HOLD |=> sw_out_ff == ($past(acts[1]) == WCTS_ACT_SET))
      else $error("second cam did not beat first cam");

   a_first_cam_acts: assert property (eval && acts[2] == WCTS_ACT_HOLD &&
      acts[1] == WCTS_ACT_HOLD && acts[0] == WCTS_ACT_SET |=> sw_out_ff)
      else $error("first cam on event ignored");

   a_hold_between: assert property (!eval |=> $stable(sw_out_ff))
      else $error("output moved without evaluation");

   a_eval_single: assert property (eval ##1 $stable({cur_day, cur_hour, cur_min}) |-> !eval)
      else $error("evaluation repeated within one minute");

   a_unset_silent: assert property (!on_ff[0][TM_SET_BIT] && !off_ff[0][TM_SET_BIT] |->
      acts[0] == WCTS_ACT_HOLD)
      else $error("unset slot produced an event");

   a_day_masked: assert property (cur_day <= DAY_LAST && !days_ff[1][cur_day] |->
      acts[1] == WCTS_ACT_HOLD)
      else $error("cam acted on an unselected day");

   a_slverr_unmapped: assert property (psel && penable && !sel.hit |-> pslverr && pready)
      else $error("unmapped access not flagged");

   c_switch_on: cover property (eval ##1 $rose(sw_out_ff));
   c_switch_off: cover property (eval ##1 $fell(sw_out_ff));
   c_conflict: cover property (eval && acts[2] == WCTS_ACT_CLR && acts[0] == WCTS_ACT_SET);
   c_reg_write: cover property (wr_go && sel.kind == WCTS_KIND_ON);
endmodule

// ---- tb/wcts_top_tb_top.sv ----
// Purpose: self-checking bench of the weekly cam time switch
// Assumes: zero wait apb slave, time base driven on pclk
// Notes: expected output from a bench model of the three cams
`timescale 1ns/1ps
module wcts_top_tb_top;
   import wcts_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] cur_day = 3'h0;
   logic [TM_HOUR_W-1:0] cur_hour = 5'h00;
   logic [TM_MIN_W-1:0] cur_min = 6'h00;
   logic switch_out;
   int n_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [DAY_NUM-1:0] m_days [CAM_NUM];
   logic [TM_W-1:0] m_on [CAM_NUM];
   logic [TM_W-1:0] m_off [CAM_NUM];
   logic m_out = 1'b0;
   logic [31:0] rd;
   logic err;
   logic [TM_W-1:0] t;
   int c;
   always #10 pclk = ~pclk;
   wcts_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cur_day(cur_day), .cur_hour(cur_hour), .cur_min(cur_min), .switch_out(switch_out));
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask
   // model cams back to their reset contents
   task automatic mreset;
      for (int k = 0; k < CAM_NUM; k++) begin
         m_days[k] = DAYS_RST;
         m_on[k] = TIME_RST;
         m_off[k] = TIME_RST;
      end
      m_out = 1'b0;
   endtask
   // master holds the request until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wcam(input int k, input logic [6:0] dy, input logic [11:0] on, input logic [11:0] off);
      m_days[k] = dy;
      m_on[k] = on;
      m_off[k] = off;
      apb(1'b1, 8'(k * 16), {25'h0, dy}, 4'hF);
      apb(1'b1, 8'(k * 16 + 4), {20'h0, on}, 4'hF);
      apb(1'b1, 8'(k * 16 + 8), {20'h0, off}, 4'hF);
      apb(1'b0, 8'(k * 16), 32'h0, 4'hF);
      chk(rd, {25'h0, dy}, "days readback");
      apb(1'b0, 8'(k * 16 + 8), 32'h0, 4'hF);
      chk(rd, {20'h0, off}, "off readback");
   endtask
   function automatic logic next_out(input logic o, input logic [2:0] d, input logic [4:0] h, input logic [5:0] m);
      logic r;
      r = o;
      for (int k = 0; k < CAM_NUM; k++) begin
         if (d < 3'h7 && m_days[k][d]) begin
            if (m_on[k][TM_SET_BIT] && m_on[k][10:0] == {h, m}) r = 1'b1;
            if (m_off[k][TM_SET_BIT] && m_off[k][10:0] == {h, m}) r = 1'b0;
         end
      end
      return r;
   endfunction
   // only a change of the time base is evaluated
   task automatic settime(input logic [2:0] d, input logic [4:0] h, input logic [5:0] m);
      @(posedge pclk);
      if ({d, h, m} != {cur_day, cur_hour, cur_min}) m_out = next_out(m_out, d, h, m);
      cur_day <= d;
      cur_hour <= h;
      cur_min <= m;
      @(posedge pclk);
      #1;
      chk({31'h0, switch_out}, {31'h0, m_out}, "switch");
   endtask
   initial begin
      void'($urandom(32'hD8299670));
      mreset();
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk({31'h0, switch_out}, 32'h0, "out after reset");
      for (int a = 0; a < 48; a += 4) begin
         apb(1'b0, 8'(a), 32'h0, 4'hF);
         chk(rd, 32'h0, "reset value");
         chk({31'h0, err}, (a % 16 == 12) ? 32'h1 : 32'h0, "error flag");
      end
      apb(1'b0, 8'h34, 32'h0, 4'hF);
      chk({31'h0, err}, 32'h1, "unmapped");
      $display("test reset done");
      wcam(0, 7'h01, 12'h800 | (12'd6 << 6) | 12'd30, 12'h800 | (12'd8 << 6));
      settime(0, 6, 29);
      settime(0, 6, 30);
      settime(0, 6, 30);
      // a rewrite while the time stands must not be evaluated again
      apb(1'b1, 8'h08, {20'h0, 12'h800 | (12'd6 << 6) | 12'd30}, 4'hF);
      repeat (2) @(posedge pclk);
      #1;
      chk({31'h0, switch_out}, 32'h1, "no re-evaluation");
      apb(1'b1, 8'h08, {20'h0, m_off[0]}, 4'hF);
      settime(1, 8, 0);
      settime(0, 8, 0);
      $display("test single cam done");
      wcam(0, 7'h7F, 12'h800 | (12'd10 << 6), 12'h000);
      wcam(1, 7'h7F, 12'd11 << 6, 12'h800 | (12'd10 << 6));
      wcam(2, 7'h04, 12'h800 | (12'd10 << 6), 12'h000);
      settime(1, 10, 0);
      settime(2, 10, 0);
      settime(3, 11, 0);
      settime(6, 10, 0);
      $display("test priority done");
      apb(1'b1, 8'h04, 32'hFFFFFFFF, 4'h1);
      m_on[0] = {m_on[0][11:8], 8'hFF};
      apb(1'b0, 8'h04, 32'h0, 4'hF);
      chk(rd, {20'h0, m_on[0]}, "byte strobe");
      apb(1'b1, OFS_STATUS, 32'hFFFFFFFF, 4'hF);
      chk({31'h0, err}, 32'h0, "status write silent");
      apb(1'b0, OFS_STATUS, 32'h0, 4'hF);
      chk(rd, (32'(cur_day) << 24) | (32'(cur_hour) << 16) | (32'(cur_min) << 8) | 32'(m_out), "status");
      $display("test status done");
      repeat (300) begin
         c = $urandom_range(0, 2);
         if ($urandom_range(0, 7) == 0) begin
            wcam(c, 7'($urandom), {1'($urandom_range(0, 3) != 0), 5'($urandom_range(0, 23)),
               6'($urandom_range(0, 59))}, {1'($urandom_range(0, 3) != 0), 5'($urandom_range(0, 23)),
               6'($urandom_range(0, 59))});
         end
         t = $urandom_range(0, 1) ? m_on[c] : m_off[c];
         if ($urandom_range(0, 3) == 0) t = {1'b0, 5'($urandom_range(0, 23)), 6'($urandom_range(0, 59))};
         settime(3'($urandom_range(0, 7)), t[10:6], t[5:0]);
      end
      $display("test random done");
      wcam(2, 7'h7F, 12'h800 | (12'd12 << 6), 12'h000);
      settime(3'h7, 5'h00, 6'h00);
      settime(0, 12, 0);
      @(posedge pclk);
      presetn <= 1'b0;
      mreset();
      @(posedge pclk);
      #1;
      chk({31'h0, switch_out}, 32'h0, "out in reset");
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h24, 32'h0, 4'hF);
      chk(rd, 32'h0, "on slot after reset");
      wcam(2, 7'h01, 12'h800 | (12'd12 << 6) | 12'd1, 12'h000);
      settime(0, 12, 1);
      $display("test mid reset done");
      final_report();
   end
endmodule
